// [logic/rtc_pkg.sv]
// Contract
// [R1] Spare bit two is free read/write and forced to 0 while oscillator halt flag is set.
// [R2] Periodic flag reads 1 while periodic output is active low, 0 otherwise.
// [R3] Level mode: writing 0 to periodic flag releases the pin until next period.
// [R4] Enabled alarm match sets its match flag about 61 us later.
// [R5] Writing 0 clears alarm flag and releases its pin; writing 1 does nothing.
// [R6] Disabled alarm flag reads 0; flag follows its interrupt pin level. Code: pin A is also driven low by the periodic flag.
// [R7] Seconds count BCD 00..59; wrap carries into minutes.
// [R8] Minutes count BCD 00..59; wrap carries into hours.
// [R9] Hours carry into day counters at PM11 to AM12 or 23 to 00.
// [R10] Any seconds write clears the sub-second divider.
// [R11] Host writes only valid time values.
// [R12] Weekday counts 0 to 6 then wraps to 0 on each day carry.
// [R13] Host avoids writing weekday 7 when weekday function is used.
// [R14] Day of month runs 1 to 31/30/29/28 by month and leap year.
// [R15] Month-day wrap bumps month 1..12; month wrap bumps year.
// [R16] Year runs BCD 00..99; multiples of four leap; wrap carries century.
// [R17] Century bit toggles on each year wrap 99 to 00.
// [R18] Host writes only valid calendar values.
// [R19] Oscillator halt flag sets on crystal stop and stays set after restart.
// [R20] While halt flag is set, control bits held 0 and interrupt pins released.
// [R21] Level mode periodic interrupt once per second, minute, hour or month.
// [R22] Counter bits holding no digit read 0 and ignore writes.
package rtc_pkg;

  localparam logic [3:0] OFS_SECONDS = 4'h0;
  localparam logic [3:0] OFS_MINUTES = 4'h1;
  localparam logic [3:0] OFS_HOURS   = 4'h2;
  localparam logic [3:0] OFS_WEEKDAY = 4'h3;
  localparam logic [3:0] OFS_MDAY    = 4'h4;
  localparam logic [3:0] OFS_MONTH   = 4'h5;
  localparam logic [3:0] OFS_YEAR    = 4'h6;
  localparam logic [3:0] OFS_CTRL2   = 4'hF;

  localparam int BIT_OSC_HALT = 4;
  localparam int BIT_SPARE    = 3;
  localparam int BIT_PERIODIC = 2;
  localparam int BIT_WEEKLY   = 1;
  localparam int BIT_DAILY    = 0;
  localparam int BIT_PM       = 5;
  localparam int BIT_CENTURY  = 7;

  localparam logic [7:0] MASK_SECONDS = 8'h7F;
  localparam logic [7:0] MASK_MINUTES = 8'h7F;
  localparam logic [7:0] MASK_HOURS   = 8'h3F;
  localparam logic [7:0] MASK_WEEKDAY = 8'h07;
  localparam logic [7:0] MASK_MDAY    = 8'h3F;
  localparam logic [7:0] MASK_MONTH   = 8'h1F;

  localparam logic [7:0] RST_TIME  = 8'h00;
  localparam logic [7:0] RST_MDAY  = 8'h01;
  localparam logic [7:0] RST_MONTH = 8'h01;

  localparam int ALARM_DELAY_NS     = 61000;
  localparam int CORE_CLK_MHZ       = 125;
  localparam int ALARM_DELAY_CYCLES = ALARM_DELAY_NS * CORE_CLK_MHZ / 1000;
  localparam int DIV_COUNT          = 32768;

  typedef enum logic [2:0] {
    PER_OFF, PER_LOW, PER_2HZ, PER_1HZ,
    PER_SEC, PER_MIN, PER_HOUR, PER_MONTH
  } periodic_mode_t;

  typedef struct packed {
    logic       en;
    logic [3:0] addr;
    logic [7:0] data;
  } reg_write_t;

endpackage

// [logic/rtc_time_calendar_counters.sv]
`timescale 1ns/1ns
module rtc_time_calendar_counters #(
  parameter int DIV_COUNT          = rtc_pkg::DIV_COUNT,
  parameter int ALARM_DELAY_CYCLES = rtc_pkg::ALARM_DELAY_CYCLES
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  input  wire logic                    osc_clk,
  input  wire rtc_pkg::reg_write_t     reg_wr,
  input  wire logic [3:0]              rd_addr,
  output logic [7:0]                   rd_data,
  input  wire rtc_pkg::periodic_mode_t periodic_select,
  input  wire logic                    hour_mode_24,
  input  wire logic                    weekly_alarm_enable,
  input  wire logic                    daily_alarm_enable,
  input  wire logic                    weekly_alarm_hit,
  input  wire logic                    daily_alarm_hit,
  input  wire logic                    osc_halt_detect,
  output logic                         irq_out_a_out,
  output logic                         irq_out_a_oe,
  output logic                         irq_out_b_out,
  output logic                         irq_out_b_oe
);

  localparam int DW = $clog2(DIV_COUNT);
  localparam int CW = $clog2(ALARM_DELAY_CYCLES + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV_COUNT - 1);
  localparam logic [DW-1:0] DIV_HALF = DW'(DIV_COUNT / 2);
  localparam logic [DW-1:0] DIV_QTR  = DW'(DIV_COUNT / 4);
  localparam logic [CW-1:0] DLY_LOAD = CW'(ALARM_DELAY_CYCLES);

  if (DIV_COUNT < 4 || (DIV_COUNT & (DIV_COUNT - 1)) != 0) begin : g_bad_div
    $error("DIV_COUNT must be a power of two of at least 4");
  end
  if (ALARM_DELAY_CYCLES < 1) begin : g_bad_dly
    $error("ALARM_DELAY_CYCLES must be at least 1");
  end

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {4'(v[7:4] + 4'h1), 4'h0};
    end
    return 8'(v + 8'h01);
  endfunction

  // Two-digit BCD year is a multiple of four
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
    return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction

  function automatic logic [7:0] month_len(input logic [7:0] mo,
                                           input logic [7:0] y);
    if (mo == 8'h02) begin
      return is_leap(y) ? 8'h29 : 8'h28;
    end
    if (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 || mo == 8'h11) begin
      return 8'h30;
    end
    return 8'h31;
  endfunction

  // Reset release, one copy per domain
  logic [1:0] core_rst_pipe;
  logic [1:0] osc_rst_pipe;
  wire        core_rst_n = core_rst_pipe[1];
  wire        osc_rst_n  = osc_rst_pipe[1];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) core_rst_pipe <= 2'h0;
    else        core_rst_pipe <= {core_rst_pipe[0], 1'b1};
  end

  always_ff @(posedge osc_clk or negedge rst_b) begin
    if (!rst_b) osc_rst_pipe <= 2'h0;
    else        osc_rst_pipe <= {osc_rst_pipe[0], 1'b1};
  end

  // Oscillator domain: sub-second divider
  logic          div_clr_tgl_reg;
  logic [2:0]    clr_sync_reg;
  logic [DW-1:0] div_cnt_reg;
  logic          tick_tgl_reg;
  logic [1:0]    phase_reg;
  wire           div_clr = clr_sync_reg[1] ^ clr_sync_reg[2];
  wire  [DW-1:0] div_next = div_clr ? '0 :
                            (div_cnt_reg == DIV_LAST) ? '0 :
                            DW'(div_cnt_reg + 1'b1);

  always_ff @(posedge osc_clk or negedge osc_rst_n) begin
    if (!osc_rst_n) begin
      clr_sync_reg <= 3'h0;
      div_cnt_reg  <= '0;
      tick_tgl_reg <= 1'b0;
      phase_reg    <= 2'h0;
    end else begin
      clr_sync_reg <= {clr_sync_reg[1:0], div_clr_tgl_reg};
      div_cnt_reg  <= div_next; // R10
      if (!div_clr && div_cnt_reg == DIV_LAST) begin
        tick_tgl_reg <= ~tick_tgl_reg;
      end
      // Low phases of the 1 Hz and 2 Hz pulse outputs
      phase_reg <= {div_next < DIV_HALF,
                    (div_next & (DIV_HALF | DIV_QTR)) < DIV_QTR ||
                    ((div_next & (DIV_HALF | DIV_QTR)) >= DIV_HALF &&
                     (div_next & (DIV_HALF | DIV_QTR)) <
                     DW'(DIV_HALF + DIV_QTR))};
    end
  end

  // Crossings into the core domain
  logic [2:0] tick_sync_reg;
  logic [1:0] ph1_sync_reg;
  logic [1:0] ph2_sync_reg;
  logic [1:0] halt_sync_reg;
  wire        sec_tick = tick_sync_reg[1] ^ tick_sync_reg[2];

  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      tick_sync_reg <= 3'h0;
      ph1_sync_reg  <= 2'h0;
      ph2_sync_reg  <= 2'h0;
      halt_sync_reg <= 2'h0;
    end else begin
      tick_sync_reg <= {tick_sync_reg[1:0], tick_tgl_reg};
      ph1_sync_reg  <= {ph1_sync_reg[0], phase_reg[1]};
      ph2_sync_reg  <= {ph2_sync_reg[0], phase_reg[0]};
      halt_sync_reg <= {halt_sync_reg[0], osc_halt_detect};
    end
  end

  // Time and calendar counters
  logic [7:0] seconds_count_reg;
  logic [7:0] minutes_count_reg;
  logic [7:0] hours_count_reg;
  logic [7:0] weekday_count_reg;
  logic [7:0] month_day_count_reg;
  logic [7:0] month_and_century_reg;
  logic [7:0] year_count_reg;

  wire  [7:0] month_now = month_and_century_reg & rtc_pkg::MASK_MONTH;
  wire  [4:0] hour12    = hours_count_reg[4:0];
  wire        hour_pm   = hours_count_reg[rtc_pkg::BIT_PM];

  wire sec_last   = seconds_count_reg == 8'h59;
  wire min_last   = minutes_count_reg == 8'h59;
  wire hour_last  = hour_mode_24 ? hours_count_reg == 8'h23 :
                                   hour_pm && hour12 == 5'h11;
  wire mday_last  = month_day_count_reg ==
                    month_len(month_now, year_count_reg);
  wire month_last = month_now == 8'h12;
  wire year_last  = year_count_reg == 8'h99;

  wire t_min   = sec_tick & sec_last; // R7
  wire t_hour  = t_min & min_last; // R8
  wire t_day   = t_hour & hour_last; // R9
  wire t_month = t_day & mday_last; // R15
  wire t_year  = t_month & month_last; // R15
  wire t_cent  = t_year & year_last; // R16

  // 12-hour mode: 12 to 01 keeps the half, 11 to 12 flips it
  wire [7:0] hour_next_12 =
    (hour12 == 5'h12) ? {2'h0, hour_pm, 5'h01} :
    (hour12 == 5'h11) ? {2'h0, ~hour_pm, 5'h12} :
    {2'h0, hour_pm, 5'(bcd_inc({3'h0, hour12}))};
  wire [7:0] hour_next_24 = hour_last ? 8'h00 : bcd_inc(hours_count_reg);

  wire wr_sec  = reg_wr.en && reg_wr.addr == rtc_pkg::OFS_SECONDS;
  wire wr_min  = reg_wr.en && reg_wr.addr == rtc_pkg::OFS_MINUTES;
  wire wr_hour = reg_wr.en && reg_wr.addr == rtc_pkg::OFS_HOURS;
  wire wr_wday = reg_wr.en && reg_wr.addr == rtc_pkg::OFS_WEEKDAY;
  wire wr_mday = reg_wr.en && reg_wr.addr == rtc_pkg::OFS_MDAY;
  wire wr_mon  = reg_wr.en && reg_wr.addr == rtc_pkg::OFS_MONTH;
  wire wr_year = reg_wr.en && reg_wr.addr == rtc_pkg::OFS_YEAR;
  wire wr_ctl  = reg_wr.en && reg_wr.addr == rtc_pkg::OFS_CTRL2;

  // Write wins over a carry landing in the same cycle
  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      seconds_count_reg     <= rtc_pkg::RST_TIME;
      minutes_count_reg     <= rtc_pkg::RST_TIME;
      hours_count_reg       <= rtc_pkg::RST_TIME;
      weekday_count_reg     <= rtc_pkg::RST_TIME;
      month_day_count_reg   <= rtc_pkg::RST_MDAY;
      month_and_century_reg <= rtc_pkg::RST_MONTH;
      year_count_reg        <= rtc_pkg::RST_TIME;
      div_clr_tgl_reg       <= 1'b0;
    end else begin
      if (wr_sec) begin
        seconds_count_reg <= reg_wr.data & rtc_pkg::MASK_SECONDS; // R22
        div_clr_tgl_reg   <= ~div_clr_tgl_reg; // R10
      end else if (sec_tick) begin
        seconds_count_reg <= sec_last ? 8'h00 : bcd_inc(seconds_count_reg); // R7
      end
      if (wr_min) begin
        minutes_count_reg <= reg_wr.data & rtc_pkg::MASK_MINUTES; // R22
      end else if (t_min) begin
        minutes_count_reg <= min_last ? 8'h00 : bcd_inc(minutes_count_reg); // R8
      end
      if (wr_hour) begin
        hours_count_reg <= reg_wr.data & rtc_pkg::MASK_HOURS; // R22
      end else if (t_hour) begin
        hours_count_reg <= hour_mode_24 ? hour_next_24 : hour_next_12; // R9
      end
      if (wr_wday) begin
        weekday_count_reg <= reg_wr.data & rtc_pkg::MASK_WEEKDAY; // R22
      end else if (t_day) begin
        weekday_count_reg <= (weekday_count_reg[2:0] == 3'h6) ? 8'h00 :
                             8'(weekday_count_reg + 8'h01); // R12
      end
      if (wr_mday) begin
        month_day_count_reg <= reg_wr.data & rtc_pkg::MASK_MDAY; // R22
      end else if (t_day) begin
        month_day_count_reg <= mday_last ? 8'h01 :
                               bcd_inc(month_day_count_reg); // R14
      end
      if (wr_mon) begin
        month_and_century_reg <= reg_wr.data &
                                 (rtc_pkg::MASK_MONTH | 8'h80); // R22
      end else if (t_month) begin
        month_and_century_reg <= {
          month_and_century_reg[rtc_pkg::BIT_CENTURY] ^ t_cent, // R17
          2'h0, 5'(month_last ? 8'h01 : bcd_inc(month_now))}; // R15
      end
      if (wr_year) begin
        year_count_reg <= reg_wr.data;
      end else if (t_year) begin
        year_count_reg <= year_last ? 8'h00 : bcd_inc(year_count_reg); // R16
      end
    end
  end

  // Flags of the control register
  logic       osc_halt_flag_reg;
  logic       spare_bit_two_reg;
  logic       level_flag_reg;
  logic [1:0] alarm_flag_reg;
  logic [CW-1:0] dly_cnt_reg [2];

  wire        level_mode = periodic_select[2];
  wire        period_hit =
    (periodic_select == rtc_pkg::PER_SEC)   ? sec_tick :
    (periodic_select == rtc_pkg::PER_MIN)   ? t_min :
    (periodic_select == rtc_pkg::PER_HOUR)  ? t_hour :
    (periodic_select == rtc_pkg::PER_MONTH) ? t_month : 1'b0; // R21
  wire        pulse_on =
    (periodic_select == rtc_pkg::PER_LOW) ? 1'b1 :
    (periodic_select == rtc_pkg::PER_2HZ) ? ph2_sync_reg[1] :
    (periodic_select == rtc_pkg::PER_1HZ) ? ph1_sync_reg[1] : 1'b0;
  wire        periodic_irq_flag = !osc_halt_flag_reg &&
                                  (level_mode ? level_flag_reg : pulse_on); // R2
  wire [1:0]  alarm_enable = {weekly_alarm_enable, daily_alarm_enable};
  wire [1:0]  alarm_hit    = {weekly_alarm_hit, daily_alarm_hit};
  wire [1:0]  alarm_vis    = alarm_flag_reg & alarm_enable &
                             {2{!osc_halt_flag_reg}}; // R6
  wire        weekly_alarm_match_flag = alarm_vis[1];
  wire        daily_alarm_match_flag  = alarm_vis[0];
  wire [1:0]  alarm_clr = {2{wr_ctl}} &
                          ~reg_wr.data[rtc_pkg::BIT_WEEKLY:rtc_pkg::BIT_DAILY];

  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      osc_halt_flag_reg <= 1'b1;
      spare_bit_two_reg <= 1'b0;
      level_flag_reg    <= 1'b0;
    end else begin
      if (halt_sync_reg[1]) begin
        osc_halt_flag_reg <= 1'b1; // R19
      end else if (wr_ctl && !reg_wr.data[rtc_pkg::BIT_OSC_HALT]) begin
        osc_halt_flag_reg <= 1'b0;
      end
      if (osc_halt_flag_reg) begin
        spare_bit_two_reg <= 1'b0; // R1
      end else if (wr_ctl) begin
        spare_bit_two_reg <= reg_wr.data[rtc_pkg::BIT_SPARE];
      end
      if (osc_halt_flag_reg || !level_mode) begin
        level_flag_reg <= 1'b0; // R20
      end else if (period_hit) begin
        level_flag_reg <= 1'b1; // R21
      end else if (wr_ctl && !reg_wr.data[rtc_pkg::BIT_PERIODIC]) begin
        level_flag_reg <= 1'b0; // R3
      end
    end
  end

  // Alarm flags rise a fixed delay after an enabled match
  for (genvar i = 0; i < 2; i++) begin : g_alarm
    always_ff @(posedge core_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
        dly_cnt_reg[i]    <= '0;
        alarm_flag_reg[i] <= 1'b0;
      end else begin
        if (osc_halt_flag_reg) begin
          dly_cnt_reg[i] <= '0;
        end else if (alarm_hit[i] && alarm_enable[i]) begin
          dly_cnt_reg[i] <= DLY_LOAD; // R4
        end else if (dly_cnt_reg[i] != '0) begin
          dly_cnt_reg[i] <= CW'(dly_cnt_reg[i] - 1'b1);
        end
        if (osc_halt_flag_reg) begin
          alarm_flag_reg[i] <= 1'b0; // R20
        end else if (dly_cnt_reg[i] == CW'(1)) begin
          alarm_flag_reg[i] <= 1'b1; // R4
        end else if (alarm_clr[i]) begin
          alarm_flag_reg[i] <= 1'b0; // R5
        end
      end
    end
  end

  // Open-drain pins: only ever pulled low
  assign irq_out_a_out = 1'b0;
  assign irq_out_b_out = 1'b0;
  assign irq_out_a_oe  = periodic_irq_flag | weekly_alarm_match_flag; // R20
  assign irq_out_b_oe  = daily_alarm_match_flag; // R6

  wire [7:0] ctrl_read = {3'h0, osc_halt_flag_reg, spare_bit_two_reg,
                          periodic_irq_flag, weekly_alarm_match_flag,
                          daily_alarm_match_flag};
  wire [7:0] rd_value =
    (rd_addr == rtc_pkg::OFS_SECONDS) ? seconds_count_reg :
    (rd_addr == rtc_pkg::OFS_MINUTES) ? minutes_count_reg :
    (rd_addr == rtc_pkg::OFS_HOURS)   ? hours_count_reg :
    (rd_addr == rtc_pkg::OFS_WEEKDAY) ? weekday_count_reg :
    (rd_addr == rtc_pkg::OFS_MDAY)    ? month_day_count_reg :
    (rd_addr == rtc_pkg::OFS_MONTH)   ? month_and_century_reg :
    (rd_addr == rtc_pkg::OFS_YEAR)    ? year_count_reg :
    (rd_addr == rtc_pkg::OFS_CTRL2)   ? ctrl_read : 8'h00;

  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) rd_data <= 8'h00;
    else             rd_data <= rd_value;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!core_rst_n);

  a_spare_halt_clr: assert property ( // R1
    osc_halt_flag_reg |=> !spare_bit_two_reg)
    else $error("spare bit survived oscillator halt");
  a_periodic_pin_track: assert property ( // R2
    periodic_irq_flag |-> irq_out_a_oe)
    else $error("periodic flag set while pin released");
  a_periodic_write_clr: assert property ( // R3
    wr_ctl && !reg_wr.data[rtc_pkg::BIT_PERIODIC] && !period_hit
    |=> !level_flag_reg)
    else $error("periodic flag not cleared by zero write");
  a_alarm_delay: assert property ( // R4
    $rose(alarm_flag_reg[1]) |-> $past(dly_cnt_reg[1]) == CW'(1))
    else $error("weekly alarm flag rose without delay expiry");
  a_alarm_write_clr: assert property ( // R5
    wr_ctl && !reg_wr.data[rtc_pkg::BIT_DAILY] && dly_cnt_reg[0] != CW'(1)
    |=> !alarm_flag_reg[0])
    else $error("daily alarm flag not cleared by zero write");
  a_alarm_read_gate: assert property ( // R6
    !daily_alarm_enable |-> !ctrl_read[rtc_pkg::BIT_DAILY] && !irq_out_b_oe)
    else $error("disabled daily alarm visible");
  a_second_wrap: assert property ( // R7
    sec_tick && sec_last && !wr_sec && !wr_min
    |=> seconds_count_reg == 8'h00 &&
        minutes_count_reg != $past(minutes_count_reg))
    else $error("seconds wrap did not carry");
  a_weekday_wrap: assert property ( // R12
    t_day && weekday_count_reg == 8'h06 && !wr_wday
    |=> weekday_count_reg == 8'h00)
    else $error("weekday did not wrap after six");
  a_century_flip: assert property ( // R17
    t_cent && !wr_mon |=> month_and_century_reg[rtc_pkg::BIT_CENTURY] !=
                          $past(month_and_century_reg[rtc_pkg::BIT_CENTURY]))
    else $error("century bit did not toggle");
  a_halt_pins_off: assert property ( // R20
    osc_halt_flag_reg |-> !irq_out_a_oe && !irq_out_b_oe)
    else $error("interrupt pin driven during halt");

endmodule // rtc_time_calendar_counters

// [verification/osc_source_model.sv]
`timescale 1ns/1ns
module osc_source_model (
  input  wire logic run,
  input  wire logic fault,
  output logic      osc_clk,
  output logic      osc_halt_detect
);
  // Crystal stands still when stopped or failed, so time can be frozen
  initial begin
    osc_clk = 1'b0;
    #1;
    forever #3 if (run && !fault) osc_clk = ~osc_clk;
  end
  assign osc_halt_detect = fault;
endmodule // osc_source_model

// [verification/rtc_time_calendar_counters_test.sv]
`timescale 1ns/1ns
module rtc_time_calendar_counters_test;
  localparam int N = 13;
  // Mode, start sec..year, expected sec..year after one tick
  localparam logic [115:0] ROWS [N] = '{
    116'h1_59592306311299_00000000018100,
    116'h1_59592302319299_00000003010100,
    116'h1_59592300280204_00000001290204,
    116'h1_59592300280201_00000001010301,
    116'h1_59592305290200_00000006010300,
    116'h1_59592300300405_00000001010505,
    116'h1_59592300300105_00000001310105,
    116'h1_59592300300905_00000001011005,
    116'h0_59593101050305_00001202060305,
    116'h0_59591101050305_00003201050305,
    116'h0_59591201050305_00000101050305,
    116'h1_59590903150721_00001003150721,
    116'h1_09290903150721_10290903150721
  };
  localparam logic [23:0] MASKS [6] = '{
    24'h03FF07, 24'h018000, 24'h02C000,
    24'h056000, 24'h04C101, 24'h085500
  };
  logic                    core_clk;
  logic                    rst_b;
  logic                    run;
  logic                    fault;
  wire logic               osc_clk;
  wire logic               osc_halt_detect;
  rtc_pkg::reg_write_t     reg_wr;
  logic [3:0]              rd_addr;
  logic [7:0]              rd_data;
  rtc_pkg::periodic_mode_t periodic_select;
  logic                    hour_mode_24;
  logic                    weekly_alarm_enable;
  logic                    daily_alarm_enable;
  logic                    weekly_alarm_hit;
  logic                    daily_alarm_hit;
  logic                    irq_out_a_out;
  logic                    irq_out_a_oe;
  logic                    irq_out_b_out;
  logic                    irq_out_b_oe;
  int                      errors;
  int                      check_count;

  osc_source_model osc (.run(run), .fault(fault), .osc_clk(osc_clk),
    .osc_halt_detect(osc_halt_detect));

  rtc_time_calendar_counters #(.DIV_COUNT(16), .ALARM_DELAY_CYCLES(5)) uut (
    .core_clk(core_clk), .rst_b(rst_b), .osc_clk(osc_clk),
    .reg_wr(reg_wr), .rd_addr(rd_addr), .rd_data(rd_data),
    .periodic_select(periodic_select), .hour_mode_24(hour_mode_24),
    .weekly_alarm_enable(weekly_alarm_enable),
    .daily_alarm_enable(daily_alarm_enable),
    .weekly_alarm_hit(weekly_alarm_hit), .daily_alarm_hit(daily_alarm_hit),
    .osc_halt_detect(osc_halt_detect), .irq_out_a_out(irq_out_a_out),
    .irq_out_a_oe(irq_out_a_oe), .irq_out_b_out(irq_out_b_out),
    .irq_out_b_oe(irq_out_b_oe));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr = '{en: 1'b1, addr: a, data: d};
    @(negedge core_clk);
    reg_wr.en = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(negedge core_clk);
    rd_addr = a;
    @(negedge core_clk);
    chk($sformatf("reg %h", a), e, rd_data);
  endtask

  // Window of 20 cycles holds exactly one tick after a seconds write
  task automatic tick_once();
    run = 1'b1;
    repeat (20) @(negedge core_clk);
    run = 1'b0;
    repeat (6) @(negedge core_clk);
  endtask

  task automatic pins(input logic ea, input logic eb);
    chk("irq_out_a_oe", {7'h00, ea}, {7'h00, irq_out_a_oe});
    chk("irq_out_b_oe", {7'h00, eb}, {7'h00, irq_out_b_oe});
    chk("irq_out_a_out", 8'h00, {7'h00, irq_out_a_out});
    chk("irq_out_b_out", 8'h00, {7'h00, irq_out_b_out});
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    report_and_stop();
  end

  initial begin
    errors = 0;
    check_count = 0;
    rst_b = 1'b0;
    run = 1'b1;
    fault = 1'b0;
    reg_wr = '0;
    rd_addr = 4'h0;
    periodic_select = rtc_pkg::PER_MONTH;
    hour_mode_24 = 1'b1;
    weekly_alarm_enable = 1'b0;
    daily_alarm_enable = 1'b0;
    weekly_alarm_hit = 1'b0;
    daily_alarm_hit = 1'b0;
    // Crystal domain ends its own reset release once it next runs
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    run = 1'b0;
    repeat (3) @(negedge core_clk);
    rd(rtc_pkg::OFS_CTRL2, 8'h10);
    pins(1'b0, 1'b0);
    for (int k = 0; k < 7; k++) begin
      rd(4'(k), (k == 4 || k == 5) ? 8'h01 : 8'h00);
    end
    wr(rtc_pkg::OFS_CTRL2, 8'h00);
    for (int i = 0; i < N; i++) begin
      hour_mode_24 = ROWS[i][112];
      wr(rtc_pkg::OFS_CTRL2, 8'h00);
      for (int k = 6; k >= 0; k--) begin
        wr(4'(k), ROWS[i][56+8*(6-k) +: 8]);
      end
      tick_once();
      for (int k = 0; k < 7; k++) begin
        rd(4'(k), ROWS[i][8*(6-k) +: 8]);
      end
      pins(ROWS[i][16 +: 8] == 8'h01, 1'b0);
    end
    periodic_select = rtc_pkg::PER_SEC;
    wr(rtc_pkg::OFS_CTRL2, 8'h08);
    rd(rtc_pkg::OFS_CTRL2, 8'h08);
    tick_once();
    rd(rtc_pkg::OFS_CTRL2, 8'h0C);
    pins(1'b1, 1'b0);
    wr(rtc_pkg::OFS_CTRL2, 8'h08);
    pins(1'b0, 1'b0);
    wr(rtc_pkg::OFS_CTRL2, 8'h0C);
    rd(rtc_pkg::OFS_CTRL2, 8'h08);
    weekly_alarm_enable = 1'b1;
    weekly_alarm_hit = 1'b1;
    @(negedge core_clk);
    weekly_alarm_hit = 1'b0;
    repeat (4) @(negedge core_clk);
    pins(1'b0, 1'b0);
    @(negedge core_clk);
    pins(1'b1, 1'b0);
    rd(rtc_pkg::OFS_CTRL2, 8'h0A);
    weekly_alarm_enable = 1'b0;
    rd(rtc_pkg::OFS_CTRL2, 8'h08);
    pins(1'b0, 1'b0);
    weekly_alarm_enable = 1'b1;
    wr(rtc_pkg::OFS_CTRL2, 8'h0A);
    rd(rtc_pkg::OFS_CTRL2, 8'h0A);
    wr(rtc_pkg::OFS_CTRL2, 8'h08);
    rd(rtc_pkg::OFS_CTRL2, 8'h08);
    pins(1'b0, 1'b0);
    daily_alarm_enable = 1'b1;
    daily_alarm_hit = 1'b1;
    @(negedge core_clk);
    daily_alarm_hit = 1'b0;
    repeat (6) @(negedge core_clk);
    rd(rtc_pkg::OFS_CTRL2, 8'h09);
    pins(1'b0, 1'b1);
    wr(rtc_pkg::OFS_CTRL2, 8'h08);
    pins(1'b0, 1'b0);
    // Divider restart: no tick early, one tick a second later
    run = 1'b1;
    wr(rtc_pkg::OFS_SECONDS, 8'h00);
    repeat (8) @(negedge core_clk);
    rd(rtc_pkg::OFS_SECONDS, 8'h00);
    repeat (8) @(negedge core_clk);
    rd(rtc_pkg::OFS_SECONDS, 8'h01);
    run = 1'b0;
    fault = 1'b1;
    repeat (5) @(negedge core_clk);
    rd(rtc_pkg::OFS_CTRL2, 8'h10);
    pins(1'b0, 1'b0);
    fault = 1'b0;
    tick_once();
    rd(rtc_pkg::OFS_CTRL2, 8'h10);
    wr(rtc_pkg::OFS_CTRL2, 8'h00);
    rd(rtc_pkg::OFS_CTRL2, 8'h00);
    periodic_select = rtc_pkg::PER_LOW;
    rd(rtc_pkg::OFS_CTRL2, 8'h04);
    pins(1'b1, 1'b0);
    periodic_select = rtc_pkg::PER_OFF;
    rd(rtc_pkg::OFS_CTRL2, 8'h00);
    pins(1'b0, 1'b0);
    for (int j = 0; j < 6; j++) begin
      wr(MASKS[j][19:16], MASKS[j][15:8]);
      rd(MASKS[j][19:16], MASKS[j][7:0]);
    end
    report_and_stop();
  end
endmodule // rtc_time_calendar_counters_test
